// ==== hw/power_good_params.svh ====
// Register offsets, field positions, reset values and interrupt bit positions for the power-good block.
`ifndef POWER_GOOD_PARAMS_SVH
`define POWER_GOOD_PARAMS_SVH

// Register offsets on the serial register port.
`define ADDR_PG_CTRL_TWO     8'h16
`define ADDR_POWER_GOOD_FAULT_SOURCES_SRC    8'h17
`define ADDR_SOFT_RESET      8'h18
`define ADDR_TOP_INT_FLAGS   8'h19

// Control register two fields and reset value.
`define BIT_PG_MODE          0
`define BIT_FAULT_DRIVES_PG  1
`define BIT_TWARN_GATES_PG   2
`define CTRL_TWO_RESET       3'h4

// Fault latch bits: buck 0, buck 1, linear 0, linear 1.
`define FAULT_LATCH_RESET    4'h0

// Soft reset command bit.
`define BIT_SOFT_RESET       0

// Top interrupt register bit positions.
`define BIT_MEAS_DONE        0
`define BIT_OVERVOLT         1
`define BIT_TWARN            2
`define BIT_TSHUTDOWN        3
`define BIT_CLK_SYNC         4
`define BIT_BUCK_SUMMARY     5
`define BIT_LINEAR_SUMMARY   6
`define BIT_PG_DROP          7
`define TOP_FLAGS_RESET      8'h00

`endif

// ==== hw/power_good_pkg.sv ====
// Types shared by the power-good and top interrupt register block.
package power_good_pkg;

    // Live monitor levels and pulses coming from the analog and clock sections.
    typedef struct packed {
        logic thermal_warn;    // Die above warning level, live.
        logic thermal_sd;      // Die above shutdown level, live.
        logic overvolt;        // Input above over-voltage level, live.
        logic ext_clk_present; // External clock detected, level.
        logic meas_done;       // Load current result ready, one-cycle pulse.
    } monitor_s;

    // Access from the serial control interface.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef logic [3:0] out_mask_t;

endpackage

// ==== hw/sticky_w1c_bank.sv ====
// Bank of sticky flags that hardware sets and software clears by writing one.
`timescale 1ns/1ps
`include "power_good_params.svh"

module sticky_w1c_bank #(
    parameter int W = 8
) (
    input  wire logic         clk,        // Core clock.
    input  wire logic         rst_n,      // Asynchronous reset, active low.
    input  wire logic         soft_clr,   // Software reset, returns all flags to zero.
    input  wire logic [W-1:0] set,        // Per-bit set request.
    input  wire logic [W-1:0] clr,        // Per-bit qualified clear request.
    output logic      [W-1:0] flags       // Current flag values.
);

    logic [W-1:0] flags_nxt;

    // One flag per bit; set beats clear so an event in the clear cycle survives.
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            always_comb begin
                if (soft_clr) begin
                    flags_nxt[i] = 1'b0;
                end else if (set[i]) begin
                    flags_nxt[i] = 1'b1;
                end else if (clr[i]) begin
                    flags_nxt[i] = 1'b0;
                end else begin
                    flags_nxt[i] = flags[i];
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flags[i] <= 1'b0;
                end else begin
                    flags[i] <= flags_nxt[i];
                end
            end
        end
    endgenerate

endmodule

// ==== hw/power_good_fault_irq_regs.sv ====
// Power-good gating, per-output fault latches, soft reset and top interrupt flags.
`timescale 1ns/1ps
`include "power_good_params.svh"

module power_good_fault_irq_regs
    import power_good_pkg::*;
(
    input  wire logic      CORE_CLK,          // Core clock, 250 MHz.
    input  wire logic      RESETN,            // Asynchronous reset, active low.
    input  wire reg_req_s  REG_REQ,           // Register access from the serial interface.
    output logic [7:0]     REG_RDATA,         // Read data, valid the cycle after rd.
    input  wire out_mask_t OUT_VALID,         // Live valid status per output.
    input  wire out_mask_t PG_SRC_EN,         // Source enables from control register one.
    input  wire logic      PG_POL,            // Polarity select from control register one.
    input  wire out_mask_t ENABLE_REQ,        // Requested regulator enables.
    input  wire monitor_s  MON,               // Live monitor levels and pulses.
    input  wire logic [7:0] BUCK_EVENTS,      // Buck event register contents.
    input  wire logic [7:0] LINEAR_EVENTS,    // Linear event register contents.
    input  wire logic      GPO_A_REQ,         // Requested level of general output a.
    input  wire logic      GPO_B_REQ,         // Requested level of general output b.
    output logic           POWER_GOOD_OUTPUT, // Power-good pin level.
    output out_mask_t      REG_ENABLE,        // Granted regulator enables.
    output logic           GENERAL_OUTPUT_A,  // General output a pin level.
    output logic           GENERAL_OUTPUT_B,  // General output b pin level.
    output logic           SOFT_RESET_PULSE   // One-cycle OTP reload and interface reset.
);

    // Control register two, the soft reset bit and the live-output state.
    logic [2:0] ctrl_r;
    logic [2:0] ctrl_nxt;
    logic       soft_rst_r;
    logic       soft_rst_nxt;
    logic       good_r;
    logic       good_nxt;
    logic       clk_seen_r;
    logic       clk_seen_nxt;
    logic       pin_r;
    logic       pin_nxt;
    out_mask_t  en_r;
    out_mask_t  en_nxt;
    logic       gpo_a_r;
    logic       gpo_a_nxt;
    logic       gpo_b_r;
    logic       gpo_b_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    out_mask_t  monitored;
    out_mask_t  failing;
    out_mask_t  fault_set;
    out_mask_t  fault_clr;
    out_mask_t  faults;
    logic [7:0] top_set;
    logic [7:0] top_clr;
    logic [7:0] top_flags;
    logic [7:0] top_view;
    logic       live_ok;
    logic       latch_ok;
    logic       warn_block;
    logic       kill;
    logic       wr_ctrl;
    logic       wr_fault;
    logic       wr_reset;
    logic       wr_top;

    assign wr_ctrl  = REG_REQ.wr && (REG_REQ.addr == `ADDR_PG_CTRL_TWO);
    assign wr_fault = REG_REQ.wr && (REG_REQ.addr == `ADDR_POWER_GOOD_FAULT_SOURCES_SRC);
    assign wr_reset = REG_REQ.wr && (REG_REQ.addr == `ADDR_SOFT_RESET);
    assign wr_top   = REG_REQ.wr && (REG_REQ.addr == `ADDR_TOP_INT_FLAGS);

    // Which outputs feed power-good. Gated mode only watches regulators that are
    // enabled, so a deliberately off rail cannot pull power-good down.
    always_comb begin
        if (ctrl_r[`BIT_PG_MODE]) begin
            monitored = PG_SRC_EN;
        end else begin
            monitored = PG_SRC_EN & en_r;
        end
        failing    = monitored & ~OUT_VALID;
        live_ok    = ~|failing;
        latch_ok   = ~|faults;
        warn_block = ctrl_r[`BIT_TWARN_GATES_PG] && MON.thermal_warn;
    end

    // Fault latches: set by a selected failing output, cleared by a one only
    // while that output is valid again.
    always_comb begin
        fault_set = failing;
        fault_clr = wr_fault ? (REG_REQ.wdata[3:0] & OUT_VALID) : 4'h0;
    end

    sticky_w1c_bank #(
        .W (4)
    ) u_fault_latches (
        .clk      (CORE_CLK),
        .rst_n    (RESETN),
        .soft_clr (soft_rst_r),
        .set      (fault_set),
        .clr      (fault_clr),
        .flags    (faults)
    );

    // Top interrupt sources. Level events keep re-setting while they persist, so a
    // clear during an ongoing shutdown does not hide it. Summary bits are never stored.
    always_comb begin
        top_set                       = 8'h00;
        top_set[`BIT_PG_DROP]         = good_r && !good_nxt && !soft_rst_r;
        top_set[`BIT_CLK_SYNC]        = MON.ext_clk_present != clk_seen_r;
        top_set[`BIT_TSHUTDOWN]       = MON.thermal_sd;
        top_set[`BIT_TWARN]           = MON.thermal_warn;
        top_set[`BIT_OVERVOLT]        = MON.overvolt;
        top_set[`BIT_MEAS_DONE]       = MON.meas_done;
        top_clr                       = wr_top ? REG_REQ.wdata : 8'h00;
        top_clr[`BIT_BUCK_SUMMARY]    = 1'b0;
        top_clr[`BIT_LINEAR_SUMMARY]  = 1'b0;
    end

    sticky_w1c_bank #(
        .W (8)
    ) u_top_flags (
        .clk      (CORE_CLK),
        .rst_n    (RESETN),
        .soft_clr (soft_rst_r),
        .set      (top_set),
        .clr      (top_clr),
        .flags    (top_flags)
    );

    // Read view of the top register with the live summary bits merged in.
    always_comb begin
        top_view                      = top_flags;
        top_view[`BIT_LINEAR_SUMMARY] = |LINEAR_EVENTS;
        top_view[`BIT_BUCK_SUMMARY]   = |BUCK_EVENTS;
    end

    // Next state of control, soft reset, pins and read data.
    always_comb begin
        ctrl_nxt     = ctrl_r;
        soft_rst_nxt = 1'b0;
        if (soft_rst_r) begin
            ctrl_nxt = `CTRL_TWO_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_nxt = REG_REQ.wdata[2:0];
            end
            if (wr_reset) begin
                soft_rst_nxt = REG_REQ.wdata[`BIT_SOFT_RESET];
            end
        end
        if (ctrl_r[`BIT_FAULT_DRIVES_PG]) begin
            good_nxt = latch_ok && !warn_block;
        end else begin
            good_nxt = live_ok && !warn_block;
        end
        clk_seen_nxt = MON.ext_clk_present;
        pin_nxt      = good_nxt ^ PG_POL;
        // Live levels also kill so the outputs drop before the flag is seen.
        kill         = top_flags[`BIT_TSHUTDOWN] || top_flags[`BIT_OVERVOLT] ||
                       MON.thermal_sd || MON.overvolt;
        en_nxt       = kill ? 4'h0 : ENABLE_REQ;
        gpo_a_nxt    = GPO_A_REQ && !kill;
        gpo_b_nxt    = GPO_B_REQ && !kill;
        rdata_nxt    = 8'h00;
        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                `ADDR_PG_CTRL_TWO:   rdata_nxt = {5'h00, ctrl_r};
                `ADDR_POWER_GOOD_FAULT_SOURCES_SRC:  rdata_nxt = {4'h0, faults};
                `ADDR_SOFT_RESET:    rdata_nxt = {7'h00, soft_rst_r};
                `ADDR_TOP_INT_FLAGS: rdata_nxt = top_view;
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    // Registers. Soft reset lasts exactly one cycle, which is also the pulse
    // handed to the OTP loader and the serial interface.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r     <= `CTRL_TWO_RESET;
            soft_rst_r <= 1'b0;
            good_r     <= 1'b0;
            clk_seen_r <= 1'b0;
            pin_r      <= 1'b0;
            en_r       <= 4'h0;
            gpo_a_r    <= 1'b0;
            gpo_b_r    <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            ctrl_r     <= ctrl_nxt;
            soft_rst_r <= soft_rst_nxt;
            good_r     <= good_nxt;
            clk_seen_r <= clk_seen_nxt;
            pin_r      <= pin_nxt;
            en_r       <= en_nxt;
            gpo_a_r    <= gpo_a_nxt;
            gpo_b_r    <= gpo_b_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    assign POWER_GOOD_OUTPUT = pin_r;
    assign REG_ENABLE        = en_r;
    assign GENERAL_OUTPUT_A  = gpo_a_r;
    assign GENERAL_OUTPUT_B  = gpo_b_r;
    assign SOFT_RESET_PULSE  = soft_rst_r;
    assign REG_RDATA         = rdata_r;

    // Checks on the block's own outputs against their causes.
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);

    property p_warn_gate;
        (ctrl_r[`BIT_TWARN_GATES_PG] && MON.thermal_warn) |=> !good_r;
    endproperty
    a_warn_gate: assert property (p_warn_gate) else $error("Warning did not gate power-good.");

    // The reset term skips the release edge, where good_r is still held in reset.
    property p_live_follow;
        (RESETN && !ctrl_r[`BIT_FAULT_DRIVES_PG] && !warn_block) |=> (good_r == $past(live_ok));
    endproperty
    a_live_follow: assert property (p_live_follow) else $error("Power-good not live.");

    property p_latch_follow;
        (ctrl_r[`BIT_FAULT_DRIVES_PG] && (faults != 4'h0)) |=> !good_r;
    endproperty
    a_latch_follow: assert property (p_latch_follow) else $error("Fault latch ignored.");

    property p_fault_set;
        (failing != 4'h0 && !soft_rst_r) |=> ((faults & $past(failing)) == $past(failing));
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("Fault latch not set.");

    property p_fault_hold;
        (wr_fault && !soft_rst_r) |=> ((faults & $past(faults & ~OUT_VALID))
                                       == $past(faults & ~OUT_VALID));
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("Invalid latch cleared.");

    property p_soft_reset;
        (wr_reset && REG_REQ.wdata[0] && !soft_rst_r) |=> soft_rst_r ##1
            (!soft_rst_r && ctrl_r == `CTRL_TWO_RESET && faults == 4'h0);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("Soft reset wrong.");

    property p_soft_self_clear;
        soft_rst_r |=> !soft_rst_r;
    endproperty
    a_soft_self_clear: assert property (p_soft_self_clear) else $error("Reset bit stuck.");

    property p_pg_drop;
        (good_r && !good_nxt && !soft_rst_r) |=> top_flags[`BIT_PG_DROP];
    endproperty
    a_pg_drop: assert property (p_pg_drop) else $error("Power-good drop not latched.");

    property p_linear_summary;
        (REG_REQ.rd && REG_REQ.addr == `ADDR_TOP_INT_FLAGS) |=>
            (REG_RDATA[6] == $past(|LINEAR_EVENTS) && REG_RDATA[5] == $past(|BUCK_EVENTS));
    endproperty
    a_linear_summary: assert property (p_linear_summary) else $error("Summary bit wrong.");

    property p_shutdown_refuse;
        top_flags[`BIT_TSHUTDOWN] |=> (REG_ENABLE == 4'h0 && !GENERAL_OUTPUT_A && !GENERAL_OUTPUT_B);
    endproperty
    a_shutdown_refuse: assert property (p_shutdown_refuse) else $error("Enable under shutdown.");

    property p_polarity;
        ##1 (POWER_GOOD_OUTPUT == (good_r ^ $past(PG_POL)));
    endproperty
    a_polarity: assert property (p_polarity) else $error("Power-good polarity wrong.");

    property p_zero_write;
        (wr_top && REG_REQ.wdata == 8'h00 && !soft_rst_r) |=>
            ((top_flags & $past(top_flags)) == $past(top_flags));
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("Zero write cleared a flag.");

    property p_fault_clear;
        (wr_fault && !soft_rst_r && fault_set == 4'h0) |=>
            ((faults & $past(fault_clr)) == 4'h0);
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("Latch not cleared.");

    property p_buck_summary;
        (REG_REQ.rd && REG_REQ.addr == `ADDR_TOP_INT_FLAGS) |=>
            (REG_RDATA[`BIT_BUCK_SUMMARY] == $past(|BUCK_EVENTS));
    endproperty
    a_buck_summary: assert property (p_buck_summary) else $error("Buck bit wrong.");

    property p_clk_sync;
        ($past(RESETN) && !soft_rst_r && MON.ext_clk_present != $past(MON.ext_clk_present))
            |=> top_flags[`BIT_CLK_SYNC];
    endproperty
    a_clk_sync: assert property (p_clk_sync) else $error("Clock change missed.");

    property p_tsd_latch;
        (MON.thermal_sd && !soft_rst_r) |=> (top_flags[`BIT_TSHUTDOWN] && REG_ENABLE == 4'h0 &&
            !GENERAL_OUTPUT_A && !GENERAL_OUTPUT_B);
    endproperty
    a_tsd_latch: assert property (p_tsd_latch) else $error("Shutdown not acted on.");

    property p_warn_latch;
        (MON.thermal_warn && !soft_rst_r) |=> top_flags[`BIT_TWARN];
    endproperty
    a_warn_latch: assert property (p_warn_latch) else $error("Warning not latched.");

    property p_ovp_latch;
        (MON.overvolt && !soft_rst_r) |=> (top_flags[`BIT_OVERVOLT] && REG_ENABLE == 4'h0 &&
            !GENERAL_OUTPUT_A && !GENERAL_OUTPUT_B);
    endproperty
    a_ovp_latch: assert property (p_ovp_latch) else $error("Overvoltage not acted on.");

    property p_meas_latch;
        (MON.meas_done && !soft_rst_r) |=> top_flags[`BIT_MEAS_DONE];
    endproperty
    a_meas_latch: assert property (p_meas_latch) else $error("Result not latched.");

    // An invalid output whose source enable is clear must not pull power-good down.
    property p_unselected;
        (RESETN && !ctrl_r[`BIT_FAULT_DRIVES_PG] && !warn_block &&
            ((PG_SRC_EN & ~OUT_VALID) == 4'h0)) |=> good_r;
    endproperty
    a_unselected: assert property (p_unselected) else $error("Unselected output used.");

    c_fault_clear: cover property (faults[0] && wr_fault && REG_REQ.wdata[0] ##1 !faults[0]);
    c_pg_drop: cover property (good_r ##1 top_flags[`BIT_PG_DROP]);
    c_soft_reset: cover property (soft_rst_r);
    c_shutdown: cover property (MON.thermal_sd && ENABLE_REQ != 4'h0 ##2 REG_ENABLE == 4'h0);

endmodule

// ==== tb/reg_host.sv ====
// Host-side model of the serial register port, issuing single reads and writes.
`timescale 1ns/1ps
module reg_host
    import power_good_pkg::*;
(
    input  wire logic       clk,   // Core clock.
    output reg_req_s        req,   // Register request toward the block.
    input  wire logic [7:0] rdata  // Registered read data from the block.
);
    // Idle request from time zero, so the block never samples an unknown strobe.
    initial begin
        req = '0;
    end

    // A write is held through the edge that samples it and dropped at that same edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    // Read data is registered, so it is taken in the cycle after the sampling edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        d = rdata;
    endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the power-good, fault latch and top interrupt registers.
`timescale 1ns/1ps
module tb;
    import power_good_pkg::*;

    logic       core_clk;
    logic       resetn;
    reg_req_s   reg_req;
    logic [7:0] reg_rdata;
    out_mask_t  out_valid;
    out_mask_t  pg_src_en;
    logic       pg_pol;
    out_mask_t  enable_req;
    monitor_s   mon;
    logic [7:0] buck_events;
    logic [7:0] linear_events;
    logic       pg_pin;
    out_mask_t  reg_enable;
    logic       gpo_a;
    logic       gpo_b;
    logic       soft_pulse;
    logic       gpo_a_req;
    logic       gpo_b_req;
    int         num_errors;
    int         cmp_count;
    int         cycles;

    power_good_fault_irq_regs u_dut (
        .CORE_CLK(core_clk), .RESETN(resetn), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
        .OUT_VALID(out_valid), .PG_SRC_EN(pg_src_en), .PG_POL(pg_pol),
        .ENABLE_REQ(enable_req), .MON(mon), .BUCK_EVENTS(buck_events),
        .LINEAR_EVENTS(linear_events), .GPO_A_REQ(gpo_a_req), .GPO_B_REQ(gpo_b_req),
        .POWER_GOOD_OUTPUT(pg_pin), .REG_ENABLE(reg_enable), .GENERAL_OUTPUT_A(gpo_a),
        .GENERAL_OUTPUT_B(gpo_b), .SOFT_RESET_PULSE(soft_pulse)
    );

    reg_host u_host (.clk(core_clk), .req(reg_req), .rdata(reg_rdata));

    // Free-running 250 MHz core clock.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // The whole run needs under two hundred cycles; a hang is cut short well above that.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Read a register and compare the bits under the mask.
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] d;
        u_host.rd(a, d);
        chk($sformatf("reg %h", a), e & m, d & m);
    endtask

    // Outputs are registered: two edges let an input change reach the pins.
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic pins(input logic pg, input out_mask_t en, input logic g);
        chk("pg pin", {7'h00, pg}, {7'h00, pg_pin});
        chk("enables", {4'h0, en}, {4'h0, reg_enable});
        chk("gpo", {6'h00, g, g}, {6'h00, gpo_a, gpo_b});
    endtask

    task automatic reset_values();
        rchk(8'h16, 8'h04, 8'hff);
        rchk(8'h17, 8'h00, 8'hff);
        rchk(8'h18, 8'h00, 8'hff);
        rchk(8'h19, 8'h00, 8'hff);
        rchk(8'h3a, 8'h00, 8'hff);
        pins(1'b1, 4'hf, 1'b1);
    endtask

    // Live tracking, latch setting, polarity, and the fault-latch source mode.
    task automatic live_and_latch();
        u_host.wr(8'h16, 8'h05);
        @(posedge core_clk);
        out_valid <= 4'hd;
        settle();
        pins(1'b1, 4'hf, 1'b1);
        out_valid <= 4'he;
        settle();
        pins(1'b0, 4'hf, 1'b1);
        rchk(8'h17, 8'h01, 8'hff);
        rchk(8'h19, 8'h80, 8'hff);
        pg_pol <= 1'b1;
        settle();
        pins(1'b1, 4'hf, 1'b1);
        pg_pol <= 1'b0;
        u_host.wr(8'h17, 8'h01);
        rchk(8'h17, 8'h01, 8'hff);
        u_host.wr(8'h16, 8'h07);
        @(posedge core_clk);
        out_valid <= 4'hf;
        settle();
        pins(1'b0, 4'hf, 1'b1);
        u_host.wr(8'h17, 8'h00);
        rchk(8'h17, 8'h01, 8'hff);
        u_host.wr(8'h17, 8'h01);
        rchk(8'h17, 8'h00, 8'hff);
        settle();
        pins(1'b1, 4'hf, 1'b1);
        u_host.wr(8'h19, 8'h00);
        rchk(8'h19, 8'h80, 8'hff);
        u_host.wr(8'h19, 8'h80);
        rchk(8'h19, 8'h00, 8'hff);
    endtask

    // Gated mode ignores a source whose regulator is not enabled; then the warning gate.
    task automatic gated_and_warn();
        u_host.wr(8'h16, 8'h04);
        @(posedge core_clk);
        enable_req <= 4'he;
        out_valid <= 4'he;
        settle();
        pins(1'b1, 4'he, 1'b1);
        out_valid <= 4'hf;
        enable_req <= 4'hf;
        u_host.wr(8'h17, 8'h0f);
        mon.thermal_warn <= 1'b1;
        settle();
        pins(1'b0, 4'hf, 1'b1);
        rchk(8'h19, 8'h04, 8'h7f);
        u_host.wr(8'h16, 8'h00);
        settle();
        pins(1'b1, 4'hf, 1'b1);
        mon.thermal_warn <= 1'b0;
        u_host.wr(8'h19, 8'hff);
        rchk(8'h19, 8'h00, 8'hff);
    endtask

    // Summary bits, one-shot events and the two protective shutdowns.
    task automatic events();
        buck_events <= 8'h10;
        linear_events <= 8'h01;
        settle();
        rchk(8'h19, 8'h60, 8'hff);
        u_host.wr(8'h19, 8'h60);
        rchk(8'h19, 8'h60, 8'hff);
        buck_events <= 8'h00;
        settle();
        rchk(8'h19, 8'h40, 8'hff);
        linear_events <= 8'h00;
        mon.meas_done <= 1'b1;
        @(posedge core_clk);
        mon.meas_done <= 1'b0;
        settle();
        rchk(8'h19, 8'h01, 8'hff);
        mon.ext_clk_present <= 1'b1;
        u_host.wr(8'h19, 8'h01);
        rchk(8'h19, 8'h10, 8'hff);
        u_host.wr(8'h19, 8'h10);
        mon.ext_clk_present <= 1'b0;
        settle();
        rchk(8'h19, 8'h10, 8'hff);
        u_host.wr(8'h19, 8'h10);
        mon.overvolt <= 1'b1;
        settle();
        pins(1'b1, 4'h0, 1'b0);
        rchk(8'h19, 8'h02, 8'h7f);
        mon.overvolt <= 1'b0;
        u_host.wr(8'h19, 8'hff);
        mon.thermal_sd <= 1'b1;
        settle();
        pins(1'b1, 4'h0, 1'b0);
        rchk(8'h19, 8'h08, 8'h7f);
        mon.thermal_sd <= 1'b0;
        settle();
        pins(1'b1, 4'h0, 1'b0);
        u_host.wr(8'h19, 8'hff);
        settle();
        pins(1'b1, 4'hf, 1'b1);
        // With no protection active each general output follows its own request.
        gpo_b_req <= 1'b0;
        settle();
        chk("gpo b", 8'h00, {7'h00, gpo_b});
        chk("gpo a", 8'h01, {7'h00, gpo_a});
        gpo_b_req <= 1'b1;
    endtask

    // Soft reset pulses once, restores defaults and reads back zero.
    task automatic soft_reset();
        int i;
        u_host.wr(8'h16, 8'h01);
        u_host.wr(8'h18, 8'h01);
        #1;
        for (i = 0; i < 3 && soft_pulse !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk("soft pulse", 8'h01, {7'h00, soft_pulse});
        @(posedge core_clk);
        #1;
        chk("soft pulse end", 8'h00, {7'h00, soft_pulse});
        rchk(8'h16, 8'h04, 8'hff);
        rchk(8'h18, 8'h00, 8'hff);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Inputs idle at time zero, reset held for sixteen cycles, then the scenarios.
    initial begin
        resetn = 1'b0;
        out_valid = 4'hf;
        pg_src_en = 4'h1;
        pg_pol = 1'b0;
        enable_req = 4'hf;
        gpo_a_req = 1'b1;
        gpo_b_req = 1'b1;
        mon = '0;
        buck_events = 8'h00;
        linear_events = 8'h00;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        settle();
        reset_values();
        live_and_latch();
        gated_and_warn();
        events();
        soft_reset();
        end_of_test();
    end
endmodule
